// >>> design/amx_cmd_exec.sv
`timescale 1ns/1ps
// Operation
// - opcodes 50,52 rotate toward decreasing position
// - opcodes 51,53 rotate toward increasing position
// - rotate: velocity mode and accu to param 2 in one write
// - velocity value is microsteps per second
// - command axis byte 0..3, type/value ignored
// - x variants take axis from x register
// - opcode 47 type: abs, rel, coordinate
// - positioning writes its target to param 0
// - positioning replies at once, never blocks
// - stop or rotate ends a running positioning
// - coordinate mode targets stored coordinate
// - opcode 54 soft stop: velocity mode, zero
// - reply status 100, value undefined
// - set-param x variant uses x register axis
module amx_cmd_exec #(
    parameter int AXES = 4
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               byte_valid,
    input  wire logic [7:0]         byte_data,
    input  wire logic [31:0]        accu_value,
    input  wire logic [7:0]         x_index,
    input  wire logic [31:0]        stored_stored_coordinate_target,
    input  wire logic [31:0]        actual_position,
    output logic                    stored_coordinate_target_req,
    output logic                    param_we,
    output logic [1:0]              param_axis,
    output logic [7:0]              param_num,
    output logic [31:0]             param_value,
    output amx_pkg::amx_mode_type   axis_mode,
    output logic                    axis_dir_up,
    output logic [AXES-1:0]         positioning,
    output logic                    reply_valid,
    output logic [7:0]              reply_status,
    output logic [31:0]             reply_value
);
    import amx_pkg::*;

    logic        frame_valid;
    logic        frame_csum_ok;
    logic [7:0]  frame_opcode;
    logic [7:0]  frame_type;
    logic [7:0]  frame_bank;
    logic [31:0] frame_value;

    // bytes arrive from same-clock uart logic, so no synchroniser here
    amx_frame_rx u_rx (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .byte_valid    (byte_valid),
        .byte_data     (byte_data),
        .frame_valid   (frame_valid),
        .frame_csum_ok (frame_csum_ok),
        .frame_opcode  (frame_opcode),
        .frame_type    (frame_type),
        .frame_bank    (frame_bank),
        .frame_value   (frame_value)
    );

    // opcode hits
    wire hit_rot_left    = (frame_opcode == OP_ROT_LEFT);
    wire hit_rot_right   = (frame_opcode == OP_ROT_RIGHT);
    wire hit_rot_left_x  = (frame_opcode == OP_ROT_LEFT_X);
    wire hit_rot_right_x = (frame_opcode == OP_ROT_RIGHT_X);
    wire hit_move_x      = (frame_opcode == OP_MOVE_POS_X);
    wire hit_stop_x      = (frame_opcode == OP_STOP_X);
    wire hit_set_param_x = (frame_opcode == OP_SET_PARAM_X);

    // decode
    wire is_rol    = hit_rot_left || hit_rot_left_x;
    wire is_ror    = hit_rot_right || hit_rot_right_x;
    wire is_xsel   = hit_rot_left_x || hit_rot_right_x
                   || hit_move_x || hit_stop_x
                   || hit_set_param_x;
    wire is_mvp    = hit_move_x;
    wire is_stop   = hit_stop_x;
    wire is_sap    = hit_set_param_x;
    wire is_turn   = is_rol || is_ror;
    wire known     = is_turn || is_mvp || is_stop || is_sap;
    // axis from x register for x variants, else bank byte
    wire [7:0] axis_sel  = is_xsel ? x_index : frame_bank;
    wire       axis_ok   = (axis_sel <= MAX_AXIS);
    wire       type_ok   = !is_mvp || (frame_type <= MODE_STORED);
    wire       is_stored_coordinate_target  = is_mvp && (frame_type == MODE_STORED);
    wire       is_rel    = is_mvp && (frame_type == MODE_RELATIVE);

    // rel adds offset with 32-bit wrap; host keeps distance in range
    wire [31:0] pos_target = is_stored_coordinate_target ? stored_stored_coordinate_target
                           : is_rel   ? actual_position + accu_value
                           : accu_value;
    // rotate writes velocity, stop writes zero to param 0 as specified
    wire [7:0]  wr_num   = is_turn ? PARAM_TGT_VEL
                         : is_sap ? frame_type
                         : PARAM_TGT_POS;
    wire [31:0] wr_value = is_turn ? accu_value
                         : is_stop ? 32'h0000_0000
                         : is_sap  ? frame_value
                         : pos_target;

    wire [7:0] status = !frame_csum_ok ? ST_BAD_CSUM
                      : !known         ? ST_BAD_CMD
                      : !type_ok       ? ST_BAD_TYPE
                      : !axis_ok       ? ST_BAD_VALUE
                      : ST_OK;
    wire       go        = frame_valid && (status == ST_OK);
    wire [1:0] axis2     = axis_sel[1:0];
    // stop shares the velocity path with rotate
    wire       vel_go    = go && (is_turn || is_stop);
    wire       move_go   = go && is_mvp;
    wire       stored_coordinate_target_hit = frame_valid && is_stored_coordinate_target;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            param_we <= 1'b0;
        end else begin
            param_we <= go;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stored_coordinate_target_req <= 1'b0;
        end else begin
            stored_coordinate_target_req <= stored_coordinate_target_hit;
        end
    end

    // reply follows every frame, refused ones too
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reply_valid <= 1'b0;
        end else begin
            reply_valid <= frame_valid;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reply_status <= 8'h00;
        end else if (frame_valid) begin
            reply_status <= status;
        end
    end

    // value carries nothing, so it stays zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reply_value <= 32'h0000_0000;
        end else if (frame_valid) begin
            reply_value <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            param_axis <= 2'b00;
        end else if (go) begin
            param_axis <= axis2;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            param_num <= 8'h00;
        end else if (go) begin
            param_num <= wr_num;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            param_value <= 32'h0000_0000;
        end else if (go) begin
            param_value <= wr_value;
        end
    end

    // mode switches in the same write as the parameter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            axis_mode <= AMX_VEL_MODE;
        end else if (vel_go) begin
            axis_mode <= AMX_VEL_MODE;
        end else if (move_go) begin
            axis_mode <= AMX_POS_MODE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            axis_dir_up <= 1'b0;
        end else if (vel_go) begin
            axis_dir_up <= is_ror;
        end
    end

    // a refused frame leaves every flag as it was
    for (genvar a = 0; a < AXES; a++) begin : g_pos
        wire sel_here = (axis2 == 2'(a));
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                positioning[a] <= 1'b0;
            end else if (vel_go && sel_here) begin
                positioning[a] <= 1'b0;
            end else if (move_go && sel_here) begin
                positioning[a] <= 1'b1;
            end
        end
    end

endmodule : amx_cmd_exec

// >>> design/amx_frame_rx.sv
`timescale 1ns/1ps
// gathers nine frame bytes and checks the 8-bit sum
module amx_frame_rx (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    output logic            frame_valid,
    output logic            frame_csum_ok,
    output logic [7:0]      frame_opcode,
    output logic [7:0]      frame_type,
    output logic [7:0]      frame_bank,
    output logic [31:0]     frame_value
);
    import amx_pkg::*;

    logic [3:0]  cnt_q;
    logic [7:0]  sum_q;
    logic [71:0] shift_q;
    wire         last_byte = (cnt_q == 4'(FRAME_BYTES - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q         <= BYTE_CNT_RST;
            sum_q         <= 8'h00;
            shift_q       <= '0;
            frame_valid   <= 1'b0;
            frame_csum_ok <= 1'b0;
        end else begin
            frame_valid <= 1'b0;
            if (byte_valid) begin
                shift_q <= {shift_q[63:0], byte_data};
                if (last_byte) begin
                    cnt_q         <= BYTE_CNT_RST;
                    sum_q         <= 8'h00;
                    frame_valid   <= 1'b1;
                    frame_csum_ok <= (sum_q == byte_data);
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                    sum_q <= sum_q + byte_data;
                end
            end
        end
    end

    // byte order: addr, opcode, type, bank, value msb first, checksum
    assign frame_opcode = shift_q[63:56];
    assign frame_type   = shift_q[55:48];
    assign frame_bank   = shift_q[47:40];
    assign frame_value  = shift_q[39:8];

endmodule : amx_frame_rx

// >>> dv/amx_cmd_exec_props.sv
`timescale 1ns/1ps
module amx_cmd_exec_props
    import amx_pkg::*;
#(parameter int AXES = 4) (
    input wire logic            clk_sys, rst_n, byte_valid, param_we, axis_dir_up, reply_valid,
    input wire logic [1:0]      param_axis,
    input wire logic [7:0]      param_num, reply_status,
    input wire amx_mode_type    axis_mode,
    input wire logic [AXES-1:0] positioning
);
    logic [3:0] cnt_q;
    logic       last_byte;
    assign last_byte = byte_valid && cnt_q == 4'h8;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) cnt_q <= 4'h0;
        else if (byte_valid) cnt_q <= last_byte ? 4'h0 : cnt_q + 4'h1;
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_end;
        last_byte;
    endsequence
    sequence s_ans;
        ##2 reply_valid;
    endsequence
    property p_reply; s_end |-> s_ans; endproperty
    a_reply: assert property (p_reply) else $error("no reply after frame");
    property p_cause; reply_valid |-> $past(last_byte, 2); endproperty
    a_cause: assert property (p_cause) else $error("reply without frame");
    property p_we; param_we == (reply_valid && reply_status == ST_OK); endproperty
    a_we: assert property (p_we) else $error("write and ok status differ");
    property p_refuse; reply_valid && reply_status != ST_OK |-> $stable(positioning); endproperty
    a_refuse: assert property (p_refuse) else $error("refused frame moved axis");
    property p_pos;
        param_we && axis_mode == AMX_POS_MODE && $past(axis_mode) != AMX_POS_MODE |->
            positioning[param_axis] && param_num == PARAM_TGT_POS;
    endproperty
    a_pos: assert property (p_pos) else $error("move not positioning");
    property p_dir; $changed(axis_dir_up) |-> param_we && axis_mode == AMX_VEL_MODE; endproperty
    a_dir: assert property (p_dir) else $error("direction changed alone");
    property p_flag; $changed(positioning) |-> param_we; endproperty
    a_flag: assert property (p_flag) else $error("positioning changed alone");
    property p_quiet; reply_valid |=> !reply_valid [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("replies too close");
endmodule : amx_cmd_exec_props
bind amx_cmd_exec amx_cmd_exec_props #(.AXES(AXES)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .byte_valid(byte_valid), .param_we(param_we),
    .axis_dir_up(axis_dir_up), .reply_valid(reply_valid), .param_axis(param_axis),
    .param_num(param_num), .reply_status(reply_status), .axis_mode(axis_mode),
    .positioning(positioning));

// >>> dv/amx_cmd_exec_tb_top.sv
`timescale 1ns/1ps
module amx_cmd_exec_tb_top;
    import amx_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, byte_valid, param_we, axis_dir_up, reply_valid, stored_coordinate_target_req;
    logic [7:0] byte_data, x_index = 8'h00, param_num, reply_status;
    logic [31:0] accu_value = 32'h0000_0000, stored_stored_coordinate_target = 32'h0000_0000;
    logic [31:0] actual_position = 32'h0000_0000, param_value, reply_value;
    logic [1:0] param_axis;
    logic [3:0] positioning;
    amx_mode_type axis_mode;
    int n_fail = 0, total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    amx_host_model host (.clk_sys(clk_sys), .byte_valid(byte_valid), .byte_data(byte_data));
    amx_cmd_exec uut (.clk_sys(clk_sys), .rst_n(rst_n), .byte_valid(byte_valid),
        .byte_data(byte_data), .accu_value(accu_value), .x_index(x_index),
        .stored_stored_coordinate_target(stored_stored_coordinate_target), .actual_position(actual_position), .stored_coordinate_target_req(stored_coordinate_target_req),
        .param_we(param_we), .param_axis(param_axis), .param_num(param_num),
        .param_value(param_value), .axis_mode(axis_mode), .axis_dir_up(axis_dir_up),
        .positioning(positioning), .reply_valid(reply_valid), .reply_status(reply_status),
        .reply_value(reply_value));
    task automatic results();
        if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one frame, then a bounded wait for the one-cycle reply
    task automatic xfer(input logic [7:0] op, typ, bank, input logic [31:0] v, input logic bad,
                        input logic [7:0] st);
        int n = 0;
        host.send(op, typ, bank, v, bad);
        do begin
            @(negedge clk_sys);
            n++;
        end while (reply_valid !== 1'b1 && n < 8);
        if (reply_valid !== 1'b1) begin
            n_fail++;
            results();
        end
        check(32'(reply_status), 32'(st));
        check(32'(param_we), 32'(st == ST_OK));
        check(reply_value, 32'h0000_0000);
    endtask : xfer
    task automatic t_rotate();
        logic [7:0] ops [4];
        ops = '{OP_ROT_LEFT, OP_ROT_RIGHT, OP_ROT_LEFT_X, OP_ROT_RIGHT_X};
        x_index = 8'h02;
        for (int i = 0; i < 4; i++) begin
            accu_value = 32'h0000_1000 + 32'(i);
            xfer(ops[i], 8'h07, 8'h03, 32'hDEAD_BEEF, 1'b0, ST_OK);
            check(32'(param_axis), i < 2 ? 32'h3 : 32'h2);
            check(32'(param_num), 32'(PARAM_TGT_VEL));
            check(param_value, accu_value);
            check(32'(axis_mode), 32'(AMX_VEL_MODE));
            check(32'(axis_dir_up), 32'(i % 2));
        end
    endtask : t_rotate
    task automatic t_move();
        accu_value = 32'h0000_0100;
        actual_position = 32'h0000_0200;
        stored_stored_coordinate_target = 32'h1234_5678;
        x_index = 8'h01;
        for (int t = 0; t < 3; t++) begin
            xfer(OP_MOVE_POS_X, 8'(t), 8'h00, 32'h0000_0000, 1'b0, ST_OK);
            check(32'(stored_coordinate_target_req), 32'(t == 2));
            check(32'(param_axis), 32'h1);
            check(param_value, t == 0 ? 32'h100 : t == 1 ? 32'h300 : 32'h1234_5678);
            check(32'(positioning), 32'h2);
        end
        xfer(OP_ROT_RIGHT_X, 8'h00, 8'h00, 32'h0000_0000, 1'b0, ST_OK);
        check(32'(positioning), 32'h0);
        xfer(OP_MOVE_POS_X, MODE_ABSOLUTE, 8'h00, 32'h0000_0000, 1'b0, ST_OK);
        xfer(OP_STOP_X, 8'h00, 8'h00, 32'h0000_0000, 1'b0, ST_OK);
        check({param_num, 22'h0, axis_mode}, 32'h0);
        check(param_value | 32'(positioning), 32'h0);
    endtask : t_move
    task automatic t_set_axis_param_xindex();
        x_index = 8'h03;
        xfer(OP_SET_PARAM_X, 8'h04, 8'h00, 32'h0000_C800, 1'b0, ST_OK);
        check({param_num, 22'h0, param_axis}, 32'h0400_0003);
        check(param_value, 32'h0000_C800);
    endtask : t_set_axis_param_xindex
    task automatic t_refuse();
        xfer(OP_ROT_LEFT, 8'h00, 8'h04, 32'h0000_0000, 1'b0, ST_BAD_VALUE);
        xfer(OP_MOVE_POS_X, 8'h03, 8'h00, 32'h0000_0000, 1'b0, ST_BAD_TYPE);
        xfer(OP_ROT_RIGHT, 8'h00, 8'h00, 32'h0000_0000, 1'b1, ST_BAD_CSUM);
        xfer(8'h37, 8'h00, 8'h00, 32'h0000_0000, 1'b0, ST_BAD_CMD);
    endtask : t_refuse
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        t_rotate();
        t_move();
        t_set_axis_param_xindex();
        t_refuse();
        results();
    end
endmodule : amx_cmd_exec_tb_top

// >>> dv/amx_host_model.sv
`timescale 1ns/1ps
// host side: whole nine-byte frames, one byte a cycle
module amx_host_model (
    input  wire logic  clk_sys,
    output logic       byte_valid,
    output logic [7:0] byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h00;
    end
    // bad adds one to the checksum so a refusal can be provoked
    task automatic send(input logic [7:0] op, typ, bank, input logic [31:0] v, input logic bad);
        logic [7:0] f [9];
        f = '{8'h01, op, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0], {7'h00, bad}};
        for (int i = 0; i < 8; i++) begin
            f[8] += f[i];
        end
        for (int i = 0; i < 9; i++) begin
            @(negedge clk_sys);
            byte_valid <= 1'b1;
            byte_data  <= f[i];
        end
        @(negedge clk_sys);
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
    endtask : send
endmodule : amx_host_model

// >>> shared/amx_pkg.sv
package amx_pkg;

    localparam int unsigned FRAME_BYTES  = 9;
    localparam logic [7:0] OP_SET_PARAM_X = 8'h10;
    localparam logic [7:0] OP_MOVE_POS_X  = 8'h2F;
    localparam logic [7:0] OP_ROT_LEFT    = 8'h32;
    localparam logic [7:0] OP_ROT_RIGHT   = 8'h33;
    localparam logic [7:0] OP_ROT_LEFT_X  = 8'h34;
    localparam logic [7:0] OP_ROT_RIGHT_X = 8'h35;
    localparam logic [7:0] OP_STOP_X      = 8'h36;
    localparam logic [7:0] MODE_ABSOLUTE  = 8'h00;
    localparam logic [7:0] MODE_RELATIVE  = 8'h01;
    localparam logic [7:0] MODE_STORED    = 8'h02;
    localparam logic [7:0] PARAM_TGT_POS = 8'h00;
    localparam logic [7:0] PARAM_TGT_VEL = 8'h02;
    localparam logic [7:0] MAX_AXIS      = 8'h03;
    localparam logic [7:0] ST_OK         = 8'h64;
    localparam logic [7:0] ST_BAD_CSUM   = 8'h01;
    localparam logic [7:0] ST_BAD_CMD    = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE   = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE  = 8'h04;
    localparam logic [3:0] BYTE_CNT_RST  = 4'h0;

    typedef enum logic [1:0] {
        AMX_VEL_MODE = 2'b00,
        AMX_POS_MODE = 2'b01
    } amx_mode_type;

endpackage : amx_pkg
